// ---- rtl/pcc_pkg.sv ----
// shared constants and types for the pll calibration and program counter bank
`default_nettype none
package pcc_pkg;
    // register offsets
    localparam logic [7:0] ADDR_FILTER = 8'h76;
    localparam logic [7:0] ADDR_WAITS = 8'h77;
    localparam logic [7:0] ADDR_BW = 8'h78;
    localparam logic [7:0] ADDR_COUNT = 8'h88;
    localparam logic [7:0] ADDR_NVM_CTRL = 8'h89;
    localparam logic [7:0] ADDR_UNLOCK = 8'ha4;
    // reset values and the default unlock code
    localparam logic [7:0] RST_FILTER = 8'h03;
    localparam logic [7:0] RST_WAITS = 8'h01;
    localparam logic [7:0] RST_BW = 8'h00;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] UNLOCK_CODE_DEF = 8'h5a;
    // writable-bit masks, the rest reads zero
    localparam logic [7:0] MASK_FILTER = 8'h07;
    localparam logic [7:0] MASK_WAITS = 8'h0f;
    localparam logic [7:0] MASK_BW = 8'h01;
    // field positions
    localparam int VCO_WAIT_LSB = 0;
    localparam int CLSD_WAIT_LSB = 2;
    localparam int BW_BIT = 0;
    localparam int CTRL_PROG_BIT = 0;
    localparam int CTRL_BUSY_BIT = 2;
    localparam int CTRL_COMMIT_BIT = 3;
    // loop filter codes and the program count limit
    localparam logic [2:0] FILTER_SECOND_ORDER = 3'h3;
    localparam logic [2:0] FILTER_THIRD_ORDER = 3'h7;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    // timing, in ns, and cycle counts at the 200 MHz clock
    localparam int CLK_PERIOD_NS = 5;
    localparam int VCO_WAIT0_NS = 20_000;
    localparam int VCO_WAIT1_NS = 400_000;
    localparam int VCO_WAIT2_NS = 8_000_000;
    localparam int VCO_WAIT3_NS = 200_000_000;
    localparam int CLSD_WAIT0_NS = 30_000;
    localparam int CLSD_WAIT1_NS = 300_000;
    localparam int CLSD_WAIT2_NS = 30_000_000;
    localparam int CLSD_WAIT3_NS = 300_000_000;
    localparam int PROG_TIME_NS = 230_000_000;
    localparam int TIMER_W = 26;
    // least times, so round up
    localparam int VCO_WAIT0_CYC = (VCO_WAIT0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int VCO_WAIT1_CYC = (VCO_WAIT1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int VCO_WAIT2_CYC = (VCO_WAIT2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int VCO_WAIT3_CYC = (VCO_WAIT3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLSD_WAIT0_CYC = (CLSD_WAIT0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLSD_WAIT1_CYC = (CLSD_WAIT1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLSD_WAIT2_CYC = (CLSD_WAIT2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLSD_WAIT3_CYC = (CLSD_WAIT3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_TIME_CYC = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // one register port transaction
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pcc_req_t;

    // stored image in the non-volatile memory
    typedef struct packed {
        logic [7:0] count;
        logic [7:0] bw;
        logic [7:0] waits;
        logic [7:0] filter;
    } pcc_image_t;

    typedef enum logic [1:0] {
        NVM_LOAD = 2'b00,
        NVM_IDLE = 2'b01,
        NVM_PROG = 2'b10
    } pcc_nvm_state_t;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_VCO = 2'b01,
        CAL_CLSD = 2'b10
    } pcc_cal_state_t;
endpackage
`default_nettype wire

// ---- rtl/pcc_timer.sv ----
// down-counting wait timer shared by calibration and programming
`default_nettype none
module pcc_timer #(
    parameter int W = pcc_pkg::TIMER_W
) (
    input wire logic clock_in,            // 200 MHz clock
    input wire logic rst_n_in,            // synchronous reset, low
    input wire logic load_in,             // start a wait of count_in cycles
    input wire logic [W-1:0] count_in,    // wait length, at least 1
    output logic expired_out              // one-cycle pulse at the end
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic run_reg;
    logic run_next;
    logic exp_reg;
    logic exp_next;

    // a fresh load restarts the wait even if one is running
    always_comb begin
        cnt_next = cnt_reg;
        run_next = run_reg;
        exp_next = 1'b0;
        if (load_in) begin
            cnt_next = count_in;
            run_next = 1'b1;
        end else if (run_reg) begin
            if (cnt_reg <= W'(1)) begin
                run_next = 1'b0;
                exp_next = 1'b1;
            end else begin
                cnt_next = cnt_reg - W'(1);
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
            exp_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            run_reg <= run_next;
            exp_reg <= exp_next;
        end
    end

    assign expired_out = exp_reg;
endmodule
`default_nettype wire

// ---- rtl/pcc_bank.sv ----
// pll calibration control registers and non-volatile program counter
`default_nettype none
module pcc_bank #(
    parameter int VCO_WAIT0_CYC = pcc_pkg::VCO_WAIT0_CYC,
    parameter int VCO_WAIT1_CYC = pcc_pkg::VCO_WAIT1_CYC,
    parameter int VCO_WAIT2_CYC = pcc_pkg::VCO_WAIT2_CYC,
    parameter int VCO_WAIT3_CYC = pcc_pkg::VCO_WAIT3_CYC,
    parameter int CLSD_WAIT0_CYC = pcc_pkg::CLSD_WAIT0_CYC,
    parameter int CLSD_WAIT1_CYC = pcc_pkg::CLSD_WAIT1_CYC,
    parameter int CLSD_WAIT2_CYC = pcc_pkg::CLSD_WAIT2_CYC,
    parameter int CLSD_WAIT3_CYC = pcc_pkg::CLSD_WAIT3_CYC,
    parameter int PROG_TIME_CYC = pcc_pkg::PROG_TIME_CYC,
    parameter logic [7:0] UNLOCK_CODE = pcc_pkg::UNLOCK_CODE_DEF
) (
    input wire logic clock_in,                   // 200 MHz clock
    input wire logic rst_n_in,                   // synchronous reset, low
    input wire pcc_pkg::pcc_req_t req_in,        // decoded port transaction
    output logic [7:0] rdata_out,                // read data, registered
    output logic rvalid_out,                     // read data valid pulse
    output logic busy_out,                       // memory load or program
    input wire pcc_pkg::pcc_image_t nvm_rd_in,   // stored image from memory
    output pcc_pkg::pcc_image_t nvm_wr_data_out, // image to program
    output logic nvm_wr_out,                     // program request pulse
    input wire logic cal_start_in,               // begin pll calibration
    output logic cal_busy_out,                   // calibration in progress
    output logic cal_done_out,                   // calibration done pulse
    output logic [2:0] filter_sel_out,           // loop filter code
    output logic filter_second_out,              // second-order selected
    output logic filter_third_out,               // third-order selected
    output logic narrow_bw_out                   // 200 Hz jitter mode
);
    localparam int TW = pcc_pkg::TIMER_W;

    // register state
    logic [7:0] filter_reg;
    logic [7:0] filter_next;
    logic [7:0] waits_reg;
    logic [7:0] waits_next;
    logic [7:0] bw_reg;
    logic [7:0] bw_next;
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic unlocked_reg;
    logic unlocked_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    // memory sequencer state
    pcc_pkg::pcc_nvm_state_t nvm_state_reg;
    pcc_pkg::pcc_nvm_state_t nvm_state_next;
    pcc_pkg::pcc_image_t wr_data_reg;
    pcc_pkg::pcc_image_t wr_data_next;
    logic nvm_wr_reg;
    logic nvm_wr_next;
    // calibration state
    pcc_pkg::pcc_cal_state_t cal_state_reg;
    pcc_pkg::pcc_cal_state_t cal_state_next;
    logic cal_done_reg;
    logic cal_done_next;
    // shared timer, plus the write-hit and program-start decodes
    logic tmr_load;
    logic [TW-1:0] tmr_count;
    logic tmr_expired;
    logic prog_go;
    logic wr_hit;

    // saturating increment of the program count
    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        if (v == pcc_pkg::COUNT_MAX) begin
            return v;
        end
        return v + 8'h01;
    endfunction

    // cycle counts for the two wait fields
    function automatic logic [TW-1:0] vco_cycles(input logic [1:0] code);
        case (code)
            2'h0: return TW'(VCO_WAIT0_CYC);
            2'h1: return TW'(VCO_WAIT1_CYC);
            2'h2: return TW'(VCO_WAIT2_CYC);
            default: return TW'(VCO_WAIT3_CYC);
        endcase
    endfunction

    function automatic logic [TW-1:0] clsd_cycles(input logic [1:0] code);
        case (code)
            2'h0: return TW'(CLSD_WAIT0_CYC);
            2'h1: return TW'(CLSD_WAIT1_CYC);
            2'h2: return TW'(CLSD_WAIT2_CYC);
            default: return TW'(CLSD_WAIT3_CYC);
        endcase
    endfunction

    // software writes land only while the memory is idle
    assign wr_hit = req_in.wr && (nvm_state_reg == pcc_pkg::NVM_IDLE);
    // program start needs the unlock write as the very last transaction
    assign prog_go = wr_hit && unlocked_reg
        && (req_in.addr == pcc_pkg::ADDR_NVM_CTRL)
        && req_in.wdata[pcc_pkg::CTRL_PROG_BIT];

    // register file, address decode and memory sequencer
    always_comb begin
        filter_next = filter_reg;
        waits_next = waits_reg;
        bw_next = bw_reg;
        count_next = count_reg;
        unlocked_next = unlocked_reg;
        rdata_next = rdata_reg;
        rvalid_next = 1'b0;
        nvm_state_next = nvm_state_reg;
        wr_data_next = wr_data_reg;
        nvm_wr_next = 1'b0;
        // any transaction spends the unlock; only the unlock write arms it
        if (req_in.wr || req_in.rd) begin
            unlocked_next = req_in.wr
                && (req_in.addr == pcc_pkg::ADDR_UNLOCK)
                && (req_in.wdata == UNLOCK_CODE);
        end
        if (wr_hit) begin
            if (req_in.addr == pcc_pkg::ADDR_FILTER) begin
                filter_next = req_in.wdata & pcc_pkg::MASK_FILTER;
            end else if (req_in.addr == pcc_pkg::ADDR_WAITS) begin
                waits_next = req_in.wdata & pcc_pkg::MASK_WAITS;
            end else if (req_in.addr == pcc_pkg::ADDR_BW) begin
                bw_next = req_in.wdata & pcc_pkg::MASK_BW;
            end else if (req_in.addr == pcc_pkg::ADDR_NVM_CTRL) begin
                if (req_in.wdata[pcc_pkg::CTRL_COMMIT_BIT]) begin
                    nvm_state_next = pcc_pkg::NVM_LOAD;
                end
            end
            // the count register and unmapped offsets drop writes
        end
        // reads are always answered, but return zero while a load is copying the image
        if (req_in.rd) begin
            rvalid_next = 1'b1;
            if (nvm_state_reg == pcc_pkg::NVM_LOAD) begin
                rdata_next = 8'h00;
            end else if (req_in.addr == pcc_pkg::ADDR_FILTER) begin
                rdata_next = filter_reg;
            end else if (req_in.addr == pcc_pkg::ADDR_WAITS) begin
                rdata_next = waits_reg;
            end else if (req_in.addr == pcc_pkg::ADDR_BW) begin
                rdata_next = bw_reg;
            end else if (req_in.addr == pcc_pkg::ADDR_COUNT) begin
                rdata_next = count_reg;
            end else if (req_in.addr == pcc_pkg::ADDR_NVM_CTRL) begin
                rdata_next = 8'h00;
                rdata_next[pcc_pkg::CTRL_BUSY_BIT] =
                    (nvm_state_reg == pcc_pkg::NVM_PROG);
            end else begin
                rdata_next = 8'h00;
            end
        end
        case (nvm_state_reg)
            pcc_pkg::NVM_LOAD: begin
                // copy the stored image, keeping reserved bits at zero
                filter_next = nvm_rd_in.filter & pcc_pkg::MASK_FILTER;
                waits_next = nvm_rd_in.waits & pcc_pkg::MASK_WAITS;
                bw_next = nvm_rd_in.bw & pcc_pkg::MASK_BW;
                count_next = nvm_rd_in.count;
                nvm_state_next = pcc_pkg::NVM_IDLE;
            end
            pcc_pkg::NVM_IDLE: begin
                if (prog_go) begin
                    // the incremented count is stored with the image
                    wr_data_next.filter = filter_reg;
                    wr_data_next.waits = waits_reg;
                    wr_data_next.bw = bw_reg;
                    wr_data_next.count = sat_inc(count_reg);
                    nvm_wr_next = 1'b1;
                    nvm_state_next = pcc_pkg::NVM_PROG;
                end
            end
            pcc_pkg::NVM_PROG: begin
                // reload once the cycle completes
                if (tmr_expired) begin
                    nvm_state_next = pcc_pkg::NVM_LOAD;
                end
            end
            default: begin
                nvm_state_next = pcc_pkg::NVM_LOAD;
            end
        endcase
    end

    // reset enters the load state so the image is copied first
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            filter_reg <= pcc_pkg::RST_FILTER;
            waits_reg <= pcc_pkg::RST_WAITS;
            bw_reg <= pcc_pkg::RST_BW;
            count_reg <= pcc_pkg::RST_COUNT;
            unlocked_reg <= 1'b0;
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
            nvm_state_reg <= pcc_pkg::NVM_LOAD;
            wr_data_reg <= '0;
            nvm_wr_reg <= 1'b0;
        end else begin
            filter_reg <= filter_next;
            waits_reg <= waits_next;
            bw_reg <= bw_next;
            count_reg <= count_next;
            unlocked_reg <= unlocked_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            nvm_state_reg <= nvm_state_next;
            wr_data_reg <= wr_data_next;
            nvm_wr_reg <= nvm_wr_next;
        end
    end

    // calibration: vco wait, then closed-loop wait
    // programming owns the timer, so calibration cannot start meanwhile
    always_comb begin
        cal_state_next = cal_state_reg;
        cal_done_next = 1'b0;
        tmr_load = 1'b0;
        tmr_count = TW'(PROG_TIME_CYC);
        if (nvm_wr_next) begin
            tmr_load = 1'b1;
        end
        case (cal_state_reg)
            pcc_pkg::CAL_IDLE: begin
                if (cal_start_in && !nvm_wr_next
                    && nvm_state_reg != pcc_pkg::NVM_PROG) begin
                    tmr_load = 1'b1;
                    tmr_count = vco_cycles(
                        waits_reg[pcc_pkg::VCO_WAIT_LSB +: 2]);
                    cal_state_next = pcc_pkg::CAL_VCO;
                end
            end
            pcc_pkg::CAL_VCO: begin
                if (tmr_expired) begin
                    tmr_load = 1'b1;
                    tmr_count = clsd_cycles(
                        waits_reg[pcc_pkg::CLSD_WAIT_LSB +: 2]);
                    cal_state_next = pcc_pkg::CAL_CLSD;
                end
            end
            pcc_pkg::CAL_CLSD: begin
                if (tmr_expired) begin
                    cal_done_next = 1'b1;
                    cal_state_next = pcc_pkg::CAL_IDLE;
                end
            end
            default: begin
                cal_state_next = pcc_pkg::CAL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            cal_state_reg <= pcc_pkg::CAL_IDLE;
            cal_done_reg <= 1'b0;
        end else begin
            cal_state_reg <= cal_state_next;
            cal_done_reg <= cal_done_next;
        end
    end

    pcc_timer #(
        .W(TW)
    ) u_timer (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .load_in(tmr_load),
        .count_in(tmr_count),
        .expired_out(tmr_expired)
    );

    // pll controls straight from the registers
    assign filter_sel_out = filter_reg[2:0];
    assign filter_second_out =
        (filter_reg[2:0] == pcc_pkg::FILTER_SECOND_ORDER);
    assign filter_third_out =
        (filter_reg[2:0] == pcc_pkg::FILTER_THIRD_ORDER);
    assign narrow_bw_out = bw_reg[pcc_pkg::BW_BIT];
    assign rdata_out = rdata_reg;
    assign rvalid_out = rvalid_reg;
    assign busy_out = (nvm_state_reg != pcc_pkg::NVM_IDLE);
    assign nvm_wr_data_out = wr_data_reg;
    assign nvm_wr_out = nvm_wr_reg;
    assign cal_busy_out = (cal_state_reg != pcc_pkg::CAL_IDLE);
    assign cal_done_out = cal_done_reg;
endmodule
`default_nettype wire

// ---- verification/pcc_bank_assertions.sv ----
// concurrent checks on the ports of the pll calibration register bank
`default_nettype none
module pcc_bank_assertions (
    input wire logic clock_in,                       // bank clock
    input wire logic rst_n_in,                       // sync reset, low
    input wire pcc_pkg::pcc_req_t req_in,            // port transaction
    input wire logic [7:0] rdata_out,                // read data
    input wire logic busy_out,                       // load or program
    input wire pcc_pkg::pcc_image_t nvm_rd_in,       // stored image
    input wire pcc_pkg::pcc_image_t nvm_wr_data_out, // image to program
    input wire logic nvm_wr_out,                     // program request
    input wire logic cal_busy_out,                   // calibration running
    input wire logic [2:0] filter_sel_out,           // filter code
    input wire logic filter_second_out,              // second order flag
    input wire logic filter_third_out,               // third order flag
    input wire logic narrow_bw_out                   // narrow bandwidth
);
    default clocking dc @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    // decoded unlock and program-start writes, kept apart so the order
    // of the two can be checked two cycles back
    logic unlock_wr;
    logic prog_wr;
    assign unlock_wr = req_in.wr && req_in.addr == pcc_pkg::ADDR_UNLOCK
        && req_in.wdata == pcc_pkg::UNLOCK_CODE_DEF;
    assign prog_wr = req_in.wr && req_in.addr == pcc_pkg::ADDR_NVM_CTRL
        && req_in.wdata[0];

    second_decode_a: assert property (
        filter_second_out == (filter_sel_out == 3'h3))
        else $error("second-order flag disagrees with filter code");
    third_decode_a: assert property (
        filter_third_out == (filter_sel_out == 3'h7))
        else $error("third-order flag disagrees with filter code");
    filter_write_a: assert property (
        req_in.wr && req_in.addr == pcc_pkg::ADDR_FILTER && !busy_out
        |=> filter_sel_out == $past(req_in.wdata[2:0]))
        else $error("filter code did not take the written value");
    bw_write_a: assert property (
        req_in.wr && req_in.addr == pcc_pkg::ADDR_BW && !busy_out
        |=> narrow_bw_out == $past(req_in.wdata[0]))
        else $error("bandwidth bit did not take the written value");
    filter_read_a: assert property (
        req_in.rd && req_in.addr == pcc_pkg::ADDR_FILTER && !busy_out
        |=> rdata_out == {5'h00, $past(filter_sel_out)})
        else $error("filter read shows set reserved bits");
    unmapped_read_a: assert property (
        req_in.rd && !(req_in.addr inside {8'h76, 8'h77, 8'h78, 8'h88,
        8'h89, 8'ha4}) |=> rdata_out == 8'h00)
        else $error("unmapped read is not zero");
    prog_unlock_a: assert property (
        nvm_wr_out |-> $past(prog_wr) && $past(unlock_wr, 2))
        else $error("program started without unlock just before");
    prog_busy_a: assert property (
        nvm_wr_out |-> busy_out [*8])
        else $error("busy dropped early in a program cycle");
    count_sat_a: assert property (
        nvm_wr_out |-> nvm_wr_data_out.count != 8'h00)
        else $error("program count wrapped past its maximum");
    load_regs_a: assert property (
        $fell(busy_out) |-> filter_sel_out == $past(nvm_rd_in.filter[2:0])
        && narrow_bw_out == $past(nvm_rd_in.bw[0]))
        else $error("registers not loaded from the stored image");
    cal_min_a: assert property (
        $rose(cal_busy_out) |-> cal_busy_out [*8])
        else $error("calibration ended before its waits");
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// self-checking bench for the pll calibration register bank
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in;
    logic rst_n_in;
    pcc_pkg::pcc_req_t req_in;
    logic [7:0] rdata_out;
    logic rvalid_out;
    logic busy_out;
    pcc_pkg::pcc_image_t mem;
    pcc_pkg::pcc_image_t nvm_wr_data_out;
    logic nvm_wr_out;
    logic cal_start_in;
    logic cal_busy_out;
    logic cal_done_out;
    logic [2:0] filter_sel_out;
    logic filter_second_out;
    logic filter_third_out;
    logic narrow_bw_out;
    int failures = 0;
    int check_count = 0;
    localparam int vw[4] = '{4, 7, 13, 29};
    localparam int cw[4] = '{6, 11, 19, 37};
    localparam int prog_cyc = 20;
    // the bench seeds the stored image through one port of the memory
    logic poke;
    pcc_pkg::pcc_image_t poke_val;

    // short waits keep the run small; expectations use vw and cw
    pcc_bank #(.VCO_WAIT0_CYC(vw[0]), .VCO_WAIT1_CYC(vw[1]),
        .VCO_WAIT2_CYC(vw[2]), .VCO_WAIT3_CYC(vw[3]),
        .CLSD_WAIT0_CYC(cw[0]), .CLSD_WAIT1_CYC(cw[1]),
        .CLSD_WAIT2_CYC(cw[2]), .CLSD_WAIT3_CYC(cw[3]),
        .PROG_TIME_CYC(prog_cyc)) uut (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .req_in(req_in),
        .rdata_out(rdata_out), .rvalid_out(rvalid_out),
        .busy_out(busy_out), .nvm_rd_in(mem),
        .nvm_wr_data_out(nvm_wr_data_out), .nvm_wr_out(nvm_wr_out),
        .cal_start_in(cal_start_in), .cal_busy_out(cal_busy_out),
        .cal_done_out(cal_done_out), .filter_sel_out(filter_sel_out),
        .filter_second_out(filter_second_out),
        .filter_third_out(filter_third_out),
        .narrow_bw_out(narrow_bw_out));

    // 200 MHz clock
    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end

    // memory keeps whatever image the bank programs
    always @(posedge clock_in) begin
        if (nvm_wr_out === 1'b1) begin
            mem <= nvm_wr_data_out;
        end else if (poke) begin
            mem <= poke_val;
        end
    end

    task automatic results;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one transaction, launched at the falling edge
    task automatic bus(input logic w, input logic r, input logic [7:0] a,
        input logic [7:0] d);
        @(negedge clock_in);
        req_in = '{wr: w, rd: r, addr: a, wdata: d};
    endtask

    task automatic idle;
        @(negedge clock_in);
        req_in = '0;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
        idle();
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp,
        input string what);
        bus(1'b0, 1'b1, a, 8'h00);
        idle();
        check("rvalid", 8'h01, {7'h00, rvalid_out});
        check(what, exp, rdata_out);
    endtask

    // the extra edge lets a just-started load raise busy first
    task automatic wait_idle;
        int i;
        @(negedge clock_in);
        for (i = 0; i < 200 && busy_out !== 1'b0; i++)
            @(negedge clock_in);
        check("busy", 8'h00, {7'h00, busy_out});
    endtask

    task automatic test_reset;
        repeat (5) @(negedge clock_in);
        check("reset filter", 8'h03, {5'h00, filter_sel_out});
        check("reset bw", 8'h00, {7'h00, narrow_bw_out});
        rst_n_in = 1'b1;
        poke = 1'b0;
        repeat (2) @(negedge clock_in);
        rd_chk(pcc_pkg::ADDR_FILTER, 8'h07, "load filter");
        rd_chk(pcc_pkg::ADDR_WAITS, 8'h0e, "load waits");
        rd_chk(pcc_pkg::ADDR_BW, 8'h01, "load bw");
        rd_chk(pcc_pkg::ADDR_COUNT, 8'hfd, "load count");
        check("third", 8'h01, {7'h00, filter_third_out});
        check("narrow", 8'h01, {7'h00, narrow_bw_out});
    endtask

    task automatic test_regs;
        wr_reg(pcc_pkg::ADDR_FILTER, 8'hfb);
        check("second", 8'h01, {7'h00, filter_second_out});
        rd_chk(pcc_pkg::ADDR_FILTER, 8'h03, "filter rw");
        wr_reg(pcc_pkg::ADDR_FILTER, 8'h05);
        check("reserved code", 8'h00,
            {6'h00, filter_second_out, filter_third_out});
        wr_reg(pcc_pkg::ADDR_BW, 8'hfe);
        check("normal bw", 8'h00, {7'h00, narrow_bw_out});
        wr_reg(pcc_pkg::ADDR_FILTER, 8'h07);
        wr_reg(pcc_pkg::ADDR_WAITS, 8'hf9);
        rd_chk(pcc_pkg::ADDR_WAITS, 8'h09, "waits rw");
        wr_reg(pcc_pkg::ADDR_COUNT, 8'h00);
        rd_chk(pcc_pkg::ADDR_COUNT, 8'hfd, "count write");
        rd_chk(8'h10, 8'h00, "unmapped");
    endtask

    task automatic prog_once(input logic [7:0] exp);
        bus(1'b1, 1'b0, pcc_pkg::ADDR_UNLOCK, pcc_pkg::UNLOCK_CODE_DEF);
        bus(1'b1, 1'b0, pcc_pkg::ADDR_NVM_CTRL, 8'h01);
        idle();
        check("prog pulse", 8'h01, {7'h00, nvm_wr_out});
        check("prog count", exp, nvm_wr_data_out.count);
        wait_idle();
        rd_chk(pcc_pkg::ADDR_COUNT, exp, "count reload");
    endtask

    // a read between unlock and start must cancel the program
    task automatic test_cancel;
        bus(1'b1, 1'b0, pcc_pkg::ADDR_UNLOCK, pcc_pkg::UNLOCK_CODE_DEF);
        bus(1'b0, 1'b1, pcc_pkg::ADDR_FILTER, 8'h00);
        bus(1'b1, 1'b0, pcc_pkg::ADDR_NVM_CTRL, 8'h01);
        idle();
        check("cancel pulse", 8'h00, {7'h00, nvm_wr_out});
        check("cancel busy", 8'h00, {7'h00, busy_out});
    endtask

    task automatic test_commit;
        @(negedge clock_in);
        poke_val = mem;
        poke_val.filter = 8'h03;
        poke_val.count = 8'h42;
        poke = 1'b1;
        wr_reg(pcc_pkg::ADDR_NVM_CTRL, 8'h08);
        poke = 1'b0;
        wait_idle();
        rd_chk(pcc_pkg::ADDR_FILTER, 8'h03, "commit filter");
        rd_chk(pcc_pkg::ADDR_COUNT, 8'h42, "commit count");
    endtask

    // returns start-to-done cycles less the two programmed waits
    task automatic cal_run(input int v, input int c, output int n);
        wr_reg(pcc_pkg::ADDR_WAITS, 8'(c * 4 + v));
        cal_start_in = 1'b1;
        @(negedge clock_in);
        cal_start_in = 1'b0;
        for (n = 0; n < 200 && cal_done_out !== 1'b1; n++)
            @(negedge clock_in);
        n = n - vw[v] - cw[c];
    endtask

    task automatic test_cal;
        int base;
        int n;
        cal_run(0, 0, base);
        for (int i = 1; i < 4; i++) begin
            cal_run(i, i, n);
            check("cal time", base[7:0], n[7:0]);
        end
        cal_run(1, 2, n);
        check("cal split", base[7:0], n[7:0]);
        cal_run(2, 1, n);
        check("cal split", base[7:0], n[7:0]);
    endtask

    initial begin
        req_in = '0;
        cal_start_in = 1'b0;
        rst_n_in = 1'b0;
        poke = 1'b1;
        poke_val = {8'hfd, 8'hff, 8'hfe, 8'hff};
        test_reset();
        test_regs();
        prog_once(8'hfe);
        prog_once(8'hff);
        prog_once(8'hff);
        test_cancel();
        test_commit();
        test_cal();
        results();
    end

    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clock_in);
        failures++;
        results();
    end
endmodule

bind pcc_bank pcc_bank_assertions chk (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .req_in(req_in), .rdata_out(rdata_out),
    .busy_out(busy_out), .nvm_rd_in(nvm_rd_in),
    .nvm_wr_data_out(nvm_wr_data_out), .nvm_wr_out(nvm_wr_out),
    .cal_busy_out(cal_busy_out), .filter_sel_out(filter_sel_out),
    .filter_second_out(filter_second_out),
    .filter_third_out(filter_third_out), .narrow_bw_out(narrow_bw_out));
`default_nettype wire
